// ==== rtl/fcp_defs.vh ====
`ifndef FCP_DEFS_VH
`define FCP_DEFS_VH
// ****************************************************************
// Step interval timing
// ****************************************************************
`define FCP_STEP_UNIT_US     500
`define FCP_CLK_MHZ          10
`define FCP_STEP_UNIT_CYC    (`FCP_STEP_UNIT_US * `FCP_CLK_MHZ)
// ****************************************************************
// Data rate codes (0 = 1 Mbit, 1 = 500 k, 2 = 250 k)
// ****************************************************************
`define FCP_RATE_1M          2'h0
`define FCP_RATE_500K        2'h1
`define FCP_RATE_250K        2'h2
// ****************************************************************
// Sector sizes
// ****************************************************************
`define FCP_SECT_BASE        16'h0080
`define FCP_SIZE_CODE_MAX    3'h7
// ****************************************************************
// Result status selectors
// ****************************************************************
`define FCP_SEL_STATUS_A     2'h0
`define FCP_SEL_STATUS_B     2'h1
`define FCP_SEL_STATUS_C     2'h2
`define FCP_SEL_STATUS_D     2'h3
// ****************************************************************
// Write gate lead
// ****************************************************************
`define FCP_PRE_ERASE_CYC    8'h04
`endif

// ==== rtl/fcp_step_timer.v ====
`timescale 1ns/10ps
`include "fcp_defs.vh"
// ****************************************************************
// Step pulse spacer
// ****************************************************************
module fcp_step_timer #(
    parameter UNIT_CYC = `FCP_STEP_UNIT_CYC
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // Control
    input  wire [3:0]  step_interval,
    input  wire [1:0]  data_rate,
    input  wire        step_req,
    // Status
    output reg         step_pulse,
    output reg         busy
);
    reg  [15:0] unit_cnt;     // Cycles within a half-ms unit
    reg  [7:0]  unit_left;    // Units still to wait
    wire [7:0]  units;        // Units for this code and rate
    wire [4:0]  base_units;   // Code 0 means the 8 ms maximum

    assign base_units = (step_interval == 4'h0) ? 5'h10 : {1'b0, step_interval};
    // Lower rate doubles the interval
    assign units = {3'h0, base_units} << data_rate;

    // Interval counter
    always @(posedge ref_clk) begin
        step_pulse <= 1'b0;
        if (rst) begin
            unit_cnt  <= 16'h0000;
            unit_left <= 8'h00;
            busy      <= 1'b0;
        end else if (!busy) begin
            if (step_req) begin   // Pulse then wait the interval
                step_pulse <= 1'b1;
                busy       <= 1'b1;
                unit_left  <= units;
                unit_cnt   <= 16'h0000;
            end
        end else if (unit_cnt == UNIT_CYC - 1) begin
            unit_cnt <= 16'h0000;
            if (unit_left != 8'h01) begin
                unit_left <= unit_left - 8'h01;
            end else if (step_req) begin  // Next step with no idle cycle between
                step_pulse <= 1'b1;
                unit_left  <= units;
            end else begin  // Interval over, nothing pending
                unit_left <= 8'h00;
                busy      <= 1'b0;
            end
        end else begin
            unit_cnt <= unit_cnt + 16'h0001;
        end
    end
endmodule // fcp_step_timer

// ==== rtl/fcp_cmd_params.v ====
`timescale 1ns/10ps
`include "fcp_defs.vh"
// Summary of operation
// - Non-DMA mode interrupts host per byte
// - DMA mode uses request and acknowledge
// - Perpendicular low bits change only when permitted
// - Polling disable stops drive polling
// - Precompensation start track is full byte
// - Sector address gives first, then increments
// - Skip drops deleted sectors on read data
// - Skip on read deleted keeps deleted only
// - Skip clear transfers every sector
// - Step spacing 0.5 to 8 ms at 1 Mbit, up to 32 ms at 250 k
// - Sector count bounds format and verify
// - Four status bytes readable in result
// - Write gate option shifts write enable
// - Present cylinder reported after sense
// - Relative seek offsets present cylinder
// - Size code zero uses data length
// - Multi-track continues onto head one only when the sector count applies
module fcp_cmd_params #(
    parameter UNIT_CYC = `FCP_STEP_UNIT_CYC
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // Command parameters
    input  wire        param_load,
    input  wire        non_dma_flag,
    input  wire        deleted_skip_flag,
    input  wire        multi_track_flag,
    input  wire        read_deleted_cmd,
    input  wire        format_cmd,
    input  wire        verify_cmd,
    input  wire        verify_count_enable,
    input  wire [7:0]  sector_address,
    input  wire [7:0]  sectors_per_track,
    input  wire [2:0]  size_code,
    input  wire [7:0]  data_length,
    input  wire        head_select,
    // Configuration
    input  wire        lock_load,
    input  wire        lock_permit,
    input  wire        perp_load,
    input  wire [3:0]  perp_bits,
    input  wire        write_pre_erase_timing,
    input  wire        polling_disable,
    input  wire        precomp_load,
    input  wire [7:0]  precomp_start_track,
    input  wire [3:0]  step_interval,
    input  wire [1:0]  data_rate,
    // Seek and sense
    input  wire        seek_load,
    input  wire        seek_relative,
    input  wire        seek_dir_out,
    input  wire [7:0]  target_cylinder,
    input  wire [7:0]  relative_cylinder_offset,
    input  wire        sense_cmd,
    // Sector engine events
    input  wire        sector_start,
    input  wire        sector_deleted,
    input  wire        byte_done,
    input  wire        write_cmd,
    input  wire        status_load,
    input  wire [31:0] status_in,
    input  wire [1:0]  status_sel,
    // DMA pins
    input  wire        dma_acknowledge_n,
    // Outputs
    output reg         dma_request,
    output reg         byte_irq,
    output reg         perp_update_permit,
    output reg  [3:0]  perp_mode,
    output reg         poll_enable,
    output reg  [7:0]  precomp_track,
    output reg  [7:0]  cur_sector,
    output reg         cur_head,
    output reg         sector_skip,
    output reg         sector_xfer,
    output reg         last_sector,
    output reg  [15:0] xfer_length,
    output reg  [7:0]  present_cylinder,
    output reg  [7:0]  sense_cylinder,
    output reg  [7:0]  status_out,
    output reg         write_enable,
    output reg         step_pulse,
    output reg         step_busy
);
    // ****************************************************************
    // Latched command fields
    // ****************************************************************
    reg        mode_non_dma;     // Transfer mode of command
    reg        skip;             // Skip flag
    reg        mtrk;             // Multi-track flag
    reg        rd_del;           // Read deleted command
    reg        count_bound;      // Sector count applies
    reg [7:0]  sec_count;        // Sectors per track
    reg [7:0]  first_sector;     // First sector of track
    reg [31:0] status_bytes;     // Four result bytes
    reg        ack_m;            // Acknowledge sync stage 1
    reg        ack_s;            // Acknowledge sync stage 2
    wire       step_req;         // Steps still outstanding
    reg [7:0]  step_left;        // Steps still to issue
    reg [7:0]  lead_cnt;         // Pre-erase lead counter
    wire       t_pulse;          // Step timer pulse
    wire       t_busy;           // Step timer busy
    reg [7:0]  next_sector;      // Next sector address
    reg        keep;             // Sector accepted
    assign step_req = (step_left != 8'h00);  // Timer restarts at once while this holds

    // ****************************************************************
    // Command field latch
    // ****************************************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            mode_non_dma <= 1'b0;
            skip         <= 1'b0;
            mtrk         <= 1'b0;
            rd_del       <= 1'b0;
            count_bound  <= 1'b0;
            sec_count    <= 8'h00;
            first_sector <= 8'h01;
            xfer_length  <= `FCP_SECT_BASE;
        end else if (param_load) begin
            mode_non_dma <= non_dma_flag;
            skip         <= deleted_skip_flag;
            mtrk         <= multi_track_flag;
            rd_del       <= read_deleted_cmd;
            count_bound  <= format_cmd | (verify_cmd & verify_count_enable);
            sec_count    <= sectors_per_track;
            first_sector <= sector_address;
            if (size_code == 3'h0) begin  // Short sector via data length
                xfer_length <= {8'h00, data_length};
            end else begin
                xfer_length <= `FCP_SECT_BASE << size_code;
            end
        end
    end

    // ****************************************************************
    // Sector sequencing and skip filter
    // ****************************************************************
    always @* begin
        next_sector = cur_sector + 8'h01;
        if (!skip) begin
            keep = 1'b1;
        end else if (rd_del) begin
            keep = sector_deleted;
        end else begin
            keep = !sector_deleted;
        end
    end

    always @(posedge ref_clk) begin
        sector_skip <= 1'b0;
        sector_xfer <= 1'b0;
        if (rst) begin
            cur_sector  <= 8'h01;
            cur_head    <= 1'b0;
            last_sector <= 1'b0;
        end else if (param_load) begin
            cur_sector  <= sector_address;
            cur_head    <= head_select;
            last_sector <= 1'b0;
        end else if (sector_start) begin
            sector_xfer <= keep;
            sector_skip <= !keep;
            if (count_bound && cur_sector == first_sector + sec_count - 8'h01) begin
                if (mtrk && !cur_head) begin  // Wrap to head one
                    cur_head   <= 1'b1;
                    cur_sector <= first_sector;
                end else begin
                    last_sector <= 1'b1;
                end
            end else begin
                cur_sector <= next_sector;
            end
        end
    end

    // ****************************************************************
    // Transfer handshake
    // ****************************************************************
    always @(posedge ref_clk) begin
        byte_irq <= 1'b0;
        if (rst) begin
            ack_m       <= 1'b1;
            ack_s       <= 1'b1;
            dma_request <= 1'b0;
        end else begin
            ack_m <= dma_acknowledge_n;
            ack_s <= ack_m;
            if (mode_non_dma) begin  // Interrupt per byte
                dma_request <= 1'b0;
                byte_irq    <= byte_done;
            end else if (byte_done) begin
                dma_request <= 1'b1;
            end else if (!ack_s) begin
                dma_request <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Configuration state
    // ****************************************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            perp_update_permit <= 1'b0;
            perp_mode          <= 4'h0;
            poll_enable        <= 1'b1;
            precomp_track      <= 8'h00;
        end else begin
            poll_enable <= !polling_disable;
            if (lock_load) begin
                perp_update_permit <= lock_permit;
            end
            if (perp_load && perp_update_permit) begin
                perp_mode <= perp_bits;
            end
            if (precomp_load) begin
                precomp_track <= precomp_start_track;
            end
        end
    end

    // ****************************************************************
    // Cylinder tracking and stepping
    // ****************************************************************
    always @(posedge ref_clk) begin
        step_pulse <= t_pulse;
        step_busy  <= t_busy | (step_left != 8'h00);
        if (rst) begin
            present_cylinder <= 8'h00;
            sense_cylinder   <= 8'h00;
            step_left        <= 8'h00;
        end else begin
            if (seek_load) begin
                if (seek_relative) begin  // Offset from present
                    step_left <= relative_cylinder_offset;
                    present_cylinder <= seek_dir_out ?
                        present_cylinder + relative_cylinder_offset :
                        present_cylinder - relative_cylinder_offset;
                end else begin
                    step_left <= (target_cylinder > present_cylinder) ?
                        target_cylinder - present_cylinder :
                        present_cylinder - target_cylinder;
                    present_cylinder <= target_cylinder;
                end
            end else if (t_pulse && step_left != 8'h00) begin  // Count each issued step
                step_left <= step_left - 8'h01;
            end
            if (sense_cmd) begin
                sense_cylinder <= present_cylinder;
            end
        end
    end

    fcp_step_timer #(
        .UNIT_CYC      (UNIT_CYC)
    ) u_step (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .step_interval (step_interval),
        .data_rate     (data_rate),
        .step_req      (step_req),
        .step_pulse    (t_pulse),
        .busy          (t_busy)
    );

    // ****************************************************************
    // Result status and write enable
    // ****************************************************************
    always @(posedge ref_clk) begin
        if (rst) begin
            status_bytes <= 32'h00000000;
            status_out   <= 8'h00;
            lead_cnt     <= 8'h00;
            write_enable <= 1'b0;
        end else begin
            if (status_load) begin
                status_bytes <= status_in;
            end
            status_out <= status_bytes[{status_sel, 3'h0} +: 8];
            if (!write_cmd) begin
                lead_cnt     <= 8'h00;
                write_enable <= 1'b0;
            end else if (!write_pre_erase_timing) begin
                write_enable <= 1'b1;
            end else if (lead_cnt == `FCP_PRE_ERASE_CYC) begin  // Hold off for pre-erase
                write_enable <= 1'b1;
            end else begin
                lead_cnt <= lead_cnt + 8'h01;
            end
        end
    end
endmodule // fcp_cmd_params

// ==== tb/fcp_props.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Parameter behaviour checker
// ****************************************************************
module fcp_props (
    // Clock, reset and loads
    input wire       ref_clk, rst, param_load, non_dma_flag, deleted_skip_flag,
    input wire       read_deleted_cmd, byte_done, byte_irq, dma_request,
    // Configuration
    input wire       perp_load, perp_update_permit, polling_disable, poll_enable,
    input wire [3:0] perp_bits, perp_mode,
    input wire       precomp_load,
    input wire [7:0] precomp_start_track, precomp_track,
    // Cylinders and sectors
    input wire       sense_cmd, sector_start, sector_deleted, sector_skip, sector_xfer,
    input wire [7:0] present_cylinder, sense_cylinder
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    reg nd_q, sk_q, rd_q;  // Latched command flags
    // Shadow of the flags taken at each parameter load
    always @(posedge ref_clk) begin
        if (rst) begin
            nd_q <= 1'b0;
            sk_q <= 1'b0;
            rd_q <= 1'b0;
        end else if (param_load) begin
            nd_q <= non_dma_flag;
            sk_q <= deleted_skip_flag;
            rd_q <= read_deleted_cmd;
        end
    end
    property p_irq; byte_done && nd_q |=> byte_irq; endproperty
    a_irq: assert property (p_irq) else $error("no byte interrupt");
    property p_nodma; nd_q && $past(nd_q) |-> !dma_request; endproperty
    a_nodma: assert property (p_nodma) else $error("request in non-dma mode");
    property p_drq; byte_done && !nd_q |=> dma_request; endproperty
    a_drq: assert property (p_drq) else $error("no dma request");
    property p_hold; perp_load && !perp_update_permit |=> $stable(perp_mode); endproperty
    a_hold: assert property (p_hold) else $error("mode changed while locked");
    property p_set; perp_load && perp_update_permit |=> perp_mode == $past(perp_bits); endproperty
    a_set: assert property (p_set) else $error("mode not updated");
    property p_poll; !$past(rst) |-> poll_enable == !$past(polling_disable); endproperty
    a_poll: assert property (p_poll) else $error("polling state wrong");
    property p_pre; precomp_load |=> precomp_track == $past(precomp_start_track); endproperty
    a_pre: assert property (p_pre) else $error("precomp track wrong");
    property p_sense; sense_cmd |=> sense_cylinder == $past(present_cylinder); endproperty
    a_sense: assert property (p_sense) else $error("sense cylinder wrong");
    property p_skip;
        sector_start && sk_q && (sector_deleted != rd_q) |=> sector_skip && !sector_xfer;
    endproperty
    a_skip: assert property (p_skip) else $error("sector not skipped");
    property p_keep;
        sector_start && !(sk_q && (sector_deleted != rd_q)) |=> sector_xfer && !sector_skip;
    endproperty
    a_keep: assert property (p_keep) else $error("sector not moved");
endmodule // fcp_props
bind fcp_cmd_params fcp_props u_props (.ref_clk, .rst, .param_load, .non_dma_flag,
    .deleted_skip_flag, .read_deleted_cmd, .byte_done, .byte_irq, .dma_request, .perp_load,
    .perp_update_permit, .polling_disable, .poll_enable, .perp_bits, .perp_mode, .precomp_load,
    .precomp_start_track, .precomp_track, .sense_cmd, .sector_start, .sector_deleted,
    .sector_skip, .sector_xfer, .present_cylinder, .sense_cylinder);

// ==== tb/fcp_dma_model.sv ====
`timescale 1ns/10ps
// ****************************************************************
// External DMA controller answering requests
// ****************************************************************
module fcp_dma_model (
    // Clock and pace
    input  wire ref_clk,
    input  wire slow,
    // DMA pins
    input  wire dma_request,
    output reg  dma_acknowledge_n
);
    integer cnt;  // Cycles since request seen
    initial begin
        dma_acknowledge_n = 1'b1;
        cnt = 0;
    end
    // Acknowledge after a short or long wait, release with request
    always @(posedge ref_clk) begin
        if (!dma_request) begin
            dma_acknowledge_n <= 1'b1;
            cnt <= 0;
        end else if (cnt >= (slow ? 6 : 1)) begin
            dma_acknowledge_n <= 1'b0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // fcp_dma_model

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Command parameter bench
// ****************************************************************
module tb_top;
    reg ref_clk = 0, rst = 1, param_load = 0, non_dma_flag = 0, deleted_skip_flag = 0;
    reg multi_track_flag = 0, read_deleted_cmd = 0, format_cmd = 0, verify_cmd = 0;
    reg verify_count_enable = 0, head_select = 0, lock_load = 0, lock_permit = 0, perp_load = 0;
    reg write_pre_erase_timing = 0, polling_disable = 0, precomp_load = 0, seek_load = 0;
    reg seek_relative = 0, seek_dir_out = 0, sense_cmd = 0, sector_start = 0, slow = 0;
    reg sector_deleted = 0, byte_done = 0, write_cmd = 0, status_load = 0;
    reg [7:0] sector_address = 1, sectors_per_track = 9, data_length = 8'h40;
    reg [7:0] precomp_start_track = 0, target_cylinder = 0, relative_cylinder_offset = 0;
    reg [2:0] size_code = 0;
    reg [3:0] perp_bits = 0, step_interval = 1;
    reg [1:0] data_rate = 0, status_sel = 0;
    reg [31:0] status_in = 0;
    wire dma_acknowledge_n, dma_request, byte_irq, perp_update_permit, poll_enable, cur_head;
    wire sector_skip, sector_xfer, last_sector, write_enable, step_pulse, step_busy;
    wire [3:0] perp_mode;
    wire [7:0] precomp_track, cur_sector, present_cylinder, sense_cylinder, status_out;
    wire [15:0] xfer_length;
    integer err_total = 0, compares = 0, i, g;
    always #50 ref_clk = ~ref_clk;
    fcp_cmd_params #(.UNIT_CYC(4)) u_dut (.*);
    fcp_dma_model u_dma (.ref_clk(ref_clk), .slow(slow), .dma_request(dma_request),
        .dma_acknowledge_n(dma_acknowledge_n));
    task wt(input integer k); repeat (k) @(posedge ref_clk); endtask
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("mismatch %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("compares %0d err_total %0d", compares, err_total);
            if (err_total == 0 && compares > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    // Command parameter load
    task lp(input nd, sk, rd, vc, mt, input [7:0] sa, spt, input [2:0] sz);
        begin
            wt(1);
            param_load <= 1; non_dma_flag <= nd; deleted_skip_flag <= sk;
            read_deleted_cmd <= rd; verify_cmd <= vc; verify_count_enable <= vc;
            multi_track_flag <= mt; sector_address <= sa; sectors_per_track <= spt;
            size_code <= sz;
            wt(1); param_load <= 0; #1;
        end
    endtask
    // One sector from the engine
    task sec(input del, input sk);
        begin
            wt(1); sector_start <= 1; sector_deleted <= del;
            wt(1); sector_start <= 0; #1;
            chk("skip", sector_skip, sk);
            chk("xfer", sector_xfer, !sk);
        end
    endtask
    // Lock then perpendicular write
    task pm(input p, input [3:0] b);
        begin
            wt(1); lock_load <= 1; lock_permit <= p;
            wt(1); lock_load <= 0; perp_load <= 1; perp_bits <= b;
            wt(1); perp_load <= 0; #1;
        end
    endtask
    // Seek, returning spacing of the first two steps
    task seek(input rel, dir, input [7:0] v, input [3:0] c, input [1:0] r, output integer gap);
        integer t, p;
        begin
            wt(1); seek_load <= 1; seek_relative <= rel; seek_dir_out <= dir;
            step_interval <= c; data_rate <= r;
            if (rel) relative_cylinder_offset <= v;
            else target_cylinder <= v;
            wt(1); seek_load <= 0; p = -1; gap = 0;
            for (t = 0; t < 3000 && (t < 4 || step_busy !== 1'b0); t = t + 1) begin
                wt(1); #1;
                if (step_pulse === 1'b1) begin
                    if (p >= 0 && gap == 0) gap = t - p;
                    p = t;
                end
            end
        end
    endtask
    // Watchdog
    initial begin
        #2000000;
        err_total = err_total + 1;
        wrap_up;
    end
    // Main sequence
    initial begin
        wt(8); rst <= 0; #1;
        chk("drq", dma_request, 0);
        chk("poll", poll_enable, 1);
        chk("sect", cur_sector, 1);
        chk("len", xfer_length, 128);
        chk("cyl", present_cylinder, 0);
        $display("test reset done");
        pm(0, 4'h5); chk("perp", perp_mode, 4'h0);
        pm(1, 4'h5); chk("perp", perp_mode, 4'h5);
        pm(0, 4'ha); chk("perp", perp_mode, 4'h5);
        wt(1); polling_disable <= 1; wt(1); #1; chk("poll", poll_enable, 0);
        wt(1); polling_disable <= 0; wt(1); #1; chk("poll", poll_enable, 1);
        for (i = 0; i < 2; i = i + 1) begin
            wt(1); precomp_load <= 1; precomp_start_track <= i ? 8'hff : 8'h00;
            wt(1); precomp_load <= 0; #1;
            chk("pre", precomp_track, i ? 8'hff : 8'h00);
        end
        $display("test config done");
        for (i = 0; i < 8; i = i + 1) begin
            lp(0, 0, 0, 0, 0, 8'h01, 8'h09, i);
            chk("len", xfer_length, i == 0 ? 16'h0040 : 16'h0080 << i);
        end
        for (i = 0; i < 8; i = i + 1) begin
            lp(0, i[2], i[1], 0, 0, 8'h01, 8'h09, 3'h2);
            sec(i[0], i[2] & (i[0] ^ i[1]));
        end
        lp(0, 0, 0, 1, 1, 8'h01, 8'h02, 3'h2);
        chk("sect", cur_sector, 1);
        sec(0, 0); wt(1); #1; chk("sect", cur_sector, 2);
        sec(0, 0); wt(1); #1;
        chk("head", cur_head, 1);
        chk("sect", cur_sector, 1);
        chk("last", last_sector, 0);
        wt(1); format_cmd <= 1; lp(0, 0, 0, 0, 0, 8'h05, 8'h01, 3'h2);
        wt(1); format_cmd <= 0; sec(0, 0); chk("last", last_sector, 1);
        $display("test sector done");
        for (i = 0; i < 3; i = i + 1) begin
            slow <= i == 1;
            lp(i == 2, 0, 0, 0, 0, 8'h01, 8'h09, 3'h2);
            wt(1); byte_done <= 1; wt(1); byte_done <= 0; #1;
            chk("irq", byte_irq, i == 2);
            chk("drq", dma_request, i != 2);
            for (g = 0; g < 20 && dma_request !== 1'b0; g = g + 1) begin wt(1); #1; end
            chk("drq", dma_request, 0);
        end
        $display("test transfer done");
        seek(0, 0, 8'h05, 4'h1, 2'h0, g); chk("gap", g, 4);
        chk("cyl", present_cylinder, 5);
        seek(1, 1, 8'h02, 4'h2, 2'h1, g); chk("gap", g, 16);
        chk("cyl", present_cylinder, 7);
        seek(1, 0, 8'h02, 4'h3, 2'h2, g); chk("gap", g, 48);
        chk("cyl", present_cylinder, 5);
        seek(1, 1, 8'h02, 4'h0, 2'h0, g); chk("gap", g, 64);
        wt(1); sense_cmd <= 1; wt(1); sense_cmd <= 0; #1;
        chk("sense", sense_cylinder, 7);
        $display("test seek done");
        wt(1); status_load <= 1; status_in <= 32'h44332211;
        wt(1); status_load <= 0;
        for (i = 0; i < 4; i = i + 1) begin
            wt(1); status_sel <= i;
            wt(1); #1; chk("status", status_out, 8'h11 * (i + 1));
        end
        wt(1); write_cmd <= 1; wt(1); #1; chk("we", write_enable, 1);
        wt(1); write_cmd <= 0; write_pre_erase_timing <= 1;
        wt(1); write_cmd <= 1; wt(4); #1; chk("we", write_enable, 0);
        wt(1); #1; chk("we", write_enable, 1);
        $display("test status done");
        wrap_up;
    end
endmodule // tb_top
